// *** core/fci_pkg.sv ***
// constants, encodings and helpers for the flash command host.
// assumes a 125 MHz system clock and a flash wired in word-wide mode.
package fci_pkg;

   // =====================================================================
   // flash command codes
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
   localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
   localparam logic [7:0] CMD_UPPER_FILL   = 8'h00;

   // =====================================================================
   // register map, byte addresses on the wishbone side
   localparam logic [7:0] REG_ADDR   = 8'h00;
   localparam logic [7:0] REG_WDATA  = 8'h04;
   localparam logic [7:0] REG_CTRL   = 8'h08;
   localparam logic [7:0] REG_PIN    = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA  = 8'h14;
   localparam logic [2:0] PIN_RST    = 3'h1;
   localparam int PIN_PD  = 0;
   localparam int PIN_UNLOCK = 1;
   localparam int PIN_VPP = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_ERR  = 1;
   localparam int ST_ID   = 2;
   localparam int ST_PEND = 3;

   // =====================================================================
   // operations started through the control register
   localparam logic [3:0] OP_RAW_WRITE   = 4'h0;
   localparam logic [3:0] OP_RAW_READ    = 4'h1;
   localparam logic [3:0] OP_READ_ARRAY  = 4'h2;
   localparam logic [3:0] OP_ERASE       = 4'h3;
   localparam logic [3:0] OP_PROGRAM     = 4'h4;
   localparam logic [3:0] OP_READ_STATUS = 4'h5;
   localparam logic [3:0] OP_READ_ID     = 4'h6;
   localparam logic [3:0] OP_CLEAR       = 4'h7;
   localparam logic [3:0] OP_LAST        = 4'h7;

   // =====================================================================
   // bus cycle timing
   localparam int CLK_PS    = 8000;
   localparam int T_AS_NS   = 20;
   localparam int T_WP_NS   = 60;
   localparam int T_WH_NS   = 20;
   localparam int T_ACC_NS  = 100;
   localparam int T_GAP_NS  = 30;
   localparam int CYC_FLOOR = 1;

   // least time in ns to whole clock cycles, never below one
   function automatic logic [7:0] cyc_f(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      if (c < CYC_FLOOR) c = CYC_FLOOR;
      return c[7:0];
   endfunction

   localparam logic [7:0] CYC_AS  = cyc_f(T_AS_NS);
   localparam logic [7:0] CYC_WP  = cyc_f(T_WP_NS);
   localparam logic [7:0] CYC_WH  = cyc_f(T_WH_NS);
   localparam logic [7:0] CYC_ACC = cyc_f(T_ACC_NS);
   localparam logic [7:0] CYC_GAP = cyc_f(T_GAP_NS);

   // =====================================================================
   // command codes the flash defines; anything else stays off the bus
   function automatic logic legal_cmd_f(input logic [7:0] c);
      return c == CMD_READ_ARRAY || c == CMD_READ_ID ||
             c == CMD_READ_STATUS || c == CMD_CLEAR_STATUS ||
             c == CMD_ERASE_SETUP || c == CMD_CONFIRM ||
             c == CMD_SUSPEND || c == CMD_PROG_SETUP ||
             c == CMD_PROG_ALT;
   endfunction

   typedef enum logic [2:0] {
      S_IDLE, S_LOAD, S_ADDR, S_WPUL, S_WREC, S_RPUL, S_GAP
   } fci_state_e;

endpackage

// *** core/fci_host.sv ***
// host controller that drives a boot-block flash through its pins and
// takes its orders from software over a classic wishbone slave.
// assumes the flash strapped word-wide and all pin inputs synchronous.
`timescale 1ns/1ps

// Behaviour
// - host writes ffh to leave identifier mode for array reads.
// - host erases with 20h then d0h, both at an address in the block.
// - host never writes codes outside the defined command set.
// - after program setup the host writes ffh twice to reach the array.
// - command writes carry 00h in the upper byte; flash ignores it.
module fci_host
   import fci_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             ce_n_o,
   output logic             oe_n_o,
   output logic             we_n_o,
   output logic             reset_powerdown_n_o,
   output logic             boot_unlock_o,
   output logic             program_supply_high_o,
   output logic      [16:0] addr_o,
   input  wire logic [15:0] dq_i,
   output logic      [15:0] dq_o,
   output logic             dq_oe_n_o
);

   // =====================================================================
   // sequencer state
   fci_state_e  st_ff, nxt_st;
   logic [7:0]  cnt_ff, nxt_cnt;
   logic [1:0]  step_ff, nxt_step;
   logic [1:0]  nsteps_ff, nxt_nsteps;
   logic [3:0]  op_ff, nxt_op;
   logic        is_rd_ff, nxt_is_rd;
   logic        is_dat_ff, nxt_is_dat;
   logic        ce_n_ff, nxt_ce_n;
   logic        oe_n_ff, nxt_oe_n;
   logic        we_n_ff, nxt_we_n;
   logic        dq_oe_n_ff, nxt_dq_oe_n;
   logic [15:0] dq_ff, nxt_dq;
   logic [16:0] fa_ff, nxt_fa;
   logic [15:0] rdata_ff, nxt_rdata;
   logic        id_mode_ff, nxt_id_mode;
   logic        pend_ff, nxt_pend;

   // =====================================================================
   // wishbone register state
   logic [16:0] addr_ff, nxt_addr;
   logic [15:0] wdata_ff, nxt_wdata;
   logic [2:0]  pin_ff, nxt_pin;
   logic        err_ff, nxt_err;
   logic        ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;
   logic        go_ff, nxt_go;
   logic [3:0]  go_op_ff, nxt_go_op;

   logic        busy;
   logic [31:0] merged;
   logic        wb_req;

   // bus steps of each operation: {is_read, is_data, data}
   function automatic logic [17:0] step_f(input logic [3:0]  op,
                                          input logic [1:0]  idx,
                                          input logic [15:0] wd);
      logic [17:0] s;
      s = {2'b00, CMD_UPPER_FILL, CMD_READ_ARRAY};
      case (op)
         OP_RAW_WRITE:   s = {2'b00, CMD_UPPER_FILL, wd[7:0]};
         OP_RAW_READ:    s = {2'b10, 16'h0000};
         OP_READ_ARRAY:  s = {2'b00, CMD_UPPER_FILL, CMD_READ_ARRAY};
         OP_ERASE:       s = (idx == 2'h0) ?
                             {2'b00, CMD_UPPER_FILL, CMD_ERASE_SETUP} :
                             {2'b00, CMD_UPPER_FILL, CMD_CONFIRM};
         OP_PROGRAM:     s = (idx == 2'h0) ?
                             {2'b00, CMD_UPPER_FILL, CMD_PROG_SETUP} :
                             {2'b01, wd};
         OP_READ_STATUS: s = (idx == 2'h0) ?
                             {2'b00, CMD_UPPER_FILL, CMD_READ_STATUS} :
                             {2'b10, 16'h0000};
         OP_READ_ID:     s = (idx == 2'h0) ?
                             {2'b00, CMD_UPPER_FILL, CMD_READ_ID} :
                             {2'b10, 16'h0000};
         OP_CLEAR:       s = {2'b00, CMD_UPPER_FILL, CMD_CLEAR_STATUS};
         default:        s = {2'b10, 16'h0000};
      endcase
      return s;
   endfunction

   // number of bus steps; read array doubles while a program setup is pending
   function automatic logic [1:0] nsteps_f(input logic [3:0] op,
                                           input logic       pend);
      logic [1:0] n;
      n = 2'h1;
      case (op)
         OP_READ_ARRAY:  n = pend ? 2'h2 : 2'h1;
         OP_ERASE,
         OP_PROGRAM,
         OP_READ_STATUS,
         OP_READ_ID:     n = 2'h2;
         default:        n = 2'h1;
      endcase
      return n;
   endfunction

   // byte lane merge for wishbone writes
   function automatic logic [31:0] lane_f(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   assign busy = (st_ff != S_IDLE) || go_ff;

   // =====================================================================
   // sequencer: one bus step at a time, counters pace every phase
   always_comb begin
      logic [17:0] s;
      s           = step_f(op_ff, step_ff, wdata_ff);
      nxt_st      = st_ff;
      nxt_cnt     = cnt_ff;
      nxt_step    = step_ff;
      nxt_nsteps  = nsteps_ff;
      nxt_op      = op_ff;
      nxt_is_rd   = is_rd_ff;
      nxt_is_dat  = is_dat_ff;
      nxt_ce_n    = ce_n_ff;
      nxt_oe_n    = oe_n_ff;
      nxt_we_n    = we_n_ff;
      nxt_dq_oe_n = dq_oe_n_ff;
      nxt_dq      = dq_ff;
      nxt_fa      = fa_ff;
      nxt_rdata   = rdata_ff;
      nxt_id_mode = id_mode_ff;
      nxt_pend    = pend_ff;
      case (st_ff)
         S_IDLE: begin
            if (go_ff) begin
               nxt_op     = go_op_ff;
               nxt_nsteps = nsteps_f(go_op_ff, pend_ff);
               nxt_step   = 2'h0;
               nxt_st     = S_LOAD;
            end
         end
         S_LOAD: begin
            // erase pair reuses the same block address for both writes
            nxt_fa      = addr_ff;
            nxt_is_rd   = s[17];
            nxt_is_dat  = s[16];
            nxt_ce_n    = 1'b0;
            nxt_dq      = s[17] ? 16'h0000 : s[15:0];
            nxt_dq_oe_n = s[17];
            nxt_cnt     = CYC_AS;
            nxt_st      = S_ADDR;
         end
         S_ADDR: begin
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
               if (is_rd_ff) begin
                  nxt_oe_n = 1'b0;
                  nxt_cnt  = CYC_ACC;
                  nxt_st   = S_RPUL;
               end else begin
                  nxt_we_n = 1'b0;
                  nxt_cnt  = CYC_WP;
                  nxt_st   = S_WPUL;
               end
            end
         end
         S_WPUL: begin
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
               nxt_we_n = 1'b1;
               nxt_cnt  = CYC_WH;
               nxt_st   = S_WREC;
               // the flash takes the write as we rises; track its mode
               if (!is_dat_ff && dq_ff[7:0] == CMD_READ_ID)
                  nxt_id_mode = 1'b1;
               else if (!is_dat_ff && dq_ff[7:0] == CMD_READ_ARRAY)
                  nxt_id_mode = 1'b0;
               // a program setup byte makes the next write data, even ffh
               nxt_pend = !is_dat_ff && !pend_ff &&
                          (dq_ff[7:0] == CMD_PROG_SETUP ||
                           dq_ff[7:0] == CMD_PROG_ALT);
            end
         end
         S_WREC: begin
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
               nxt_ce_n    = 1'b1;
               nxt_dq_oe_n = 1'b1;
               nxt_cnt     = CYC_GAP;
               nxt_st      = S_GAP;
            end
         end
         S_RPUL: begin
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
               nxt_rdata = dq_i;
               nxt_oe_n  = 1'b1;
               nxt_ce_n  = 1'b1;
               nxt_cnt   = CYC_GAP;
               nxt_st    = S_GAP;
            end
         end
         S_GAP: begin
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
               if (step_ff + 2'h1 < nsteps_ff) begin
                  nxt_step = step_ff + 2'h1;
                  nxt_st   = S_LOAD;
               end else begin
                  nxt_st = S_IDLE;
               end
            end
         end
         default: nxt_st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff      <= S_IDLE;
         cnt_ff     <= 8'h00;
         step_ff    <= 2'h0;
         nsteps_ff  <= 2'h0;
         op_ff      <= OP_RAW_READ;
         is_rd_ff   <= 1'b0;
         is_dat_ff  <= 1'b0;
         ce_n_ff    <= 1'b1;
         oe_n_ff    <= 1'b1;
         we_n_ff    <= 1'b1;
         dq_oe_n_ff <= 1'b1;
         dq_ff      <= 16'h0000;
         fa_ff      <= 17'h00000;
         rdata_ff   <= 16'h0000;
         id_mode_ff <= 1'b0;
         pend_ff    <= 1'b0;
      end else begin
         st_ff      <= nxt_st;
         cnt_ff     <= nxt_cnt;
         step_ff    <= nxt_step;
         nsteps_ff  <= nxt_nsteps;
         op_ff      <= nxt_op;
         is_rd_ff   <= nxt_is_rd;
         is_dat_ff  <= nxt_is_dat;
         ce_n_ff    <= nxt_ce_n;
         oe_n_ff    <= nxt_oe_n;
         we_n_ff    <= nxt_we_n;
         dq_oe_n_ff <= nxt_dq_oe_n;
         dq_ff      <= nxt_dq;
         fa_ff      <= nxt_fa;
         rdata_ff   <= nxt_rdata;
         id_mode_ff <= nxt_id_mode;
         pend_ff    <= nxt_pend;
      end
   end

   // =====================================================================
   // wishbone slave: one wait state, every address acknowledged
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;

   always_comb begin
      merged    = 32'h00000000;
      nxt_addr  = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_pin   = pin_ff;
      nxt_err   = err_ff;
      nxt_ack   = wb_req;
      nxt_dat   = dat_ff;
      nxt_go    = 1'b0;
      nxt_go_op = go_op_ff;
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            REG_ADDR: begin
               merged   = lane_f({15'h0000, addr_ff}, wb_dat_i, wb_sel_i);
               nxt_addr = merged[16:0];
            end
            REG_WDATA: begin
               merged    = lane_f({16'h0000, wdata_ff}, wb_dat_i, wb_sel_i);
               nxt_wdata = merged[15:0];
            end
            REG_CTRL: begin
               // refuse while busy, unknown ops and undefined raw codes
               if (!wb_sel_i[0] || busy || wb_dat_i[3:0] > OP_LAST ||
                   (wb_dat_i[3:0] == OP_RAW_WRITE &&
                    !legal_cmd_f(wdata_ff[7:0]))) begin
                  nxt_err = 1'b1;
               end else begin
                  nxt_go    = 1'b1;
                  nxt_go_op = wb_dat_i[3:0];
               end
            end
            REG_PIN: begin
               if (wb_sel_i[0]) nxt_pin = wb_dat_i[2:0];
            end
            REG_STATUS: begin
               // write one clears; only a refused control write sets it again
               if (wb_sel_i[0] && wb_dat_i[ST_ERR]) nxt_err = 1'b0;
            end
            default: nxt_err = err_ff;
         endcase
      end
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            REG_ADDR:   nxt_dat = {15'h0000, addr_ff};
            REG_WDATA:  nxt_dat = {16'h0000, wdata_ff};
            REG_PIN:    nxt_dat = {29'h00000000, pin_ff};
            REG_STATUS: nxt_dat = {28'h0000000, pend_ff, id_mode_ff,
                                   err_ff, busy};
            REG_RDATA:  nxt_dat = {16'h0000, rdata_ff};
            default:    nxt_dat = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_ff  <= 17'h00000;
         wdata_ff <= 16'h0000;
         pin_ff   <= PIN_RST;
         err_ff   <= 1'b0;
         ack_ff   <= 1'b0;
         dat_ff   <= 32'h00000000;
         go_ff    <= 1'b0;
         go_op_ff <= OP_RAW_READ;
      end else begin
         addr_ff  <= nxt_addr;
         wdata_ff <= nxt_wdata;
         pin_ff   <= nxt_pin;
         err_ff   <= nxt_err;
         ack_ff   <= nxt_ack;
         dat_ff   <= nxt_dat;
         go_ff    <= nxt_go;
         go_op_ff <= nxt_go_op;
      end
   end

   // pins; power-down is held after reset until software releases it
   assign wb_ack_o              = ack_ff;
   assign wb_dat_o              = dat_ff;
   assign ce_n_o                = ce_n_ff;
   assign oe_n_o                = oe_n_ff;
   assign we_n_o                = we_n_ff;
   assign dq_o                  = dq_ff;
   assign dq_oe_n_o             = dq_oe_n_ff;
   assign addr_o                = fa_ff;
   assign reset_powerdown_n_o   = !pin_ff[PIN_PD];
   assign boot_unlock_o         = pin_ff[PIN_UNLOCK];
   assign program_supply_high_o = pin_ff[PIN_VPP];

   // =====================================================================
   // checks
   legal_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(we_n_o) && !is_dat_ff |-> legal_cmd_f(dq_o[7:0]))
      else $error("undefined command code driven");

   upper_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(we_n_o) && !is_dat_ff |-> dq_o[15:8] == CMD_UPPER_FILL)
      else $error("command upper byte not filled");

   erase_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(we_n_o) && op_ff == OP_ERASE && step_ff == 2'h1 |->
      dq_o[7:0] == CMD_CONFIRM && addr_o == addr_ff)
      else $error("erase confirm wrong code or block");

   ff_twice_a: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff == S_IDLE && go_ff && go_op_ff == OP_READ_ARRAY && pend_ff
      |=> nsteps_ff == 2'h2)
      else $error("single ffh after program setup");

   id_leave_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(we_n_o) && !is_dat_ff && dq_o[7:0] == CMD_READ_ARRAY
      |-> !id_mode_ff)
      else $error("identifier mode kept after ffh");

   rw_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !we_n_o |-> oe_n_o && !dq_oe_n_o && !ce_n_o)
      else $error("write strobe without select or data");

   wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

endmodule

// *** testbench/fci_flash_model.sv ***
// behavioural boot-block flash: command decoder, read path, timed
// write state machine
// assumes word-wide strapping and a host that keeps the bus timing
`timescale 1ns/1ps
module fci_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h5A3C, // arbitrary value
   parameter logic [16:0] BOOT_END = 17'h01FFF,
   parameter int          WSM_NS   = 3000
) (
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        reset_powerdown_n_i,
   input  wire logic        unlock_i,
   input  wire logic        vpp_i,
   input  wire logic [16:0] addr_i,
   input  wire logic [15:0] dq_i,
   output logic      [15:0] dq_o,
   output logic             drive_o
);
   // ==================================================================
   // state
   logic [15:0] mem [int];
   logic [6:0]  sr    = 7'h00;
   logic [1:0]  mode  = 2'd0; // 0 array, 1 identifier, 2 status
   logic [1:0]  setup = 2'd0; // 1 program, 2 erase
   logic        ers   = 1'b0;
   logic        susp  = 1'b0;
   time         done_t = 0;
   time         rest   = 0;
   wire         strobe = ~(ce_n_i | we_n_i);

   // drives only with select and output enable active and reset released
   assign drive_o = ~ce_n_i & ~oe_n_i & reset_powerdown_n_i;

   function automatic logic busy_f();
      return !susp && $time < done_t;
   endfunction

   // ==================================================================
   // read path, latched at the later falling strobe
   always @(negedge oe_n_i or negedge ce_n_i) begin
      if (mode == 2'd2)
         dq_o = {8'h00, !busy_f(), sr};
      else if (mode == 2'd1)
         dq_o = addr_i[0] ? DEV_CODE : MFR_CODE;
      else
         dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
   end

   // ==================================================================
   // command capture at the end of the write strobe
   always @(negedge strobe or negedge reset_powerdown_n_i) begin
      if (!reset_powerdown_n_i) begin
         mode = 2'd0;
         setup = 2'd0;
         susp = 1'b0;
         done_t = 0;
      end else if (busy_f() || susp) begin
         if (dq_i[7:0] == 8'h70)
            mode = 2'd2;
         else if (ers && !susp && dq_i[7:0] == 8'hB0) begin
            susp = 1'b1;
            rest = done_t - $time;
         end else if (susp && dq_i[7:0] == 8'hD0) begin
            susp = 1'b0;
            done_t = $time + rest;
         end else if (susp && dq_i[7:0] == 8'hFF)
            mode = 2'd0;
      end else if (setup != 2'd0) begin
         mode = 2'd2;
         if (setup == 2'd2 && dq_i[7:0] == 8'hFF)
            mode = 2'd0;
         else if (setup == 2'd2 && dq_i[7:0] != 8'hD0)
            sr[5:4] = 2'b11;
         else if (!vpp_i) begin
            sr[3] = 1'b1;
            sr[3 + setup] = 1'b1;
         end else if (addr_i <= BOOT_END && !unlock_i)
            sr[3 + setup] = 1'b1;
         else begin
            ers = setup == 2'd2;
            done_t = $time + WSM_NS;
            if (!ers)
               mem[addr_i] = dq_o_f(addr_i) & dq_i;
         end
         setup = 2'd0;
      end else
         case (dq_i[7:0])
            8'hFF: mode = 2'd0;
            8'h90: mode = 2'd1;
            8'h70: mode = 2'd2;
            8'h50: sr[5:3] = 3'b000;
            8'h20: setup = 2'd2;
            8'h40, 8'h10: setup = 2'd1;
            default: ; // reserved codes do nothing
         endcase
   end

   function automatic logic [15:0] dq_o_f(input logic [16:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for fci_host with a behavioural flash on its pins
// assumes one 125 MHz clock and the flash model in word-wide mode
`timescale 1ns/1ps
module tb_top;
   import fci_pkg::*;
   localparam int          WSM_NS = 3000;
   localparam logic [15:0] MFR    = 16'h00A5; // arbitrary value
   localparam logic [15:0] DEV    = 16'h5A3C; // arbitrary value
   logic        clk_i, rst_i, cyc, stb, we, ack, fdrv, dq_oe_n;
   logic        ce_n, oe_n, we_n, pdown_n, unl, vpp;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [16:0] fa, a;
   logic [15:0] dq_i, dq_o, fdq, d;
   logic [15:0] last = 16'h0000;
   logic [31:0] wdat, rdat, q;
   int          n_mismatch, checked;

   // undriven bus toggles each cycle instead of keeping stale data
   assign dq_i = !dq_oe_n ? dq_o : fdrv ? fdq : ~last;
   always @(posedge clk_i) last <= dq_i;

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   fci_host fci_host_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .ce_n_o(ce_n), .oe_n_o(oe_n),
      .we_n_o(we_n), .reset_powerdown_n_o(pdown_n), .boot_unlock_o(unl),
      .program_supply_high_o(vpp), .addr_o(fa), .dq_i, .dq_o,
      .dq_oe_n_o(dq_oe_n));
   fci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .WSM_NS(WSM_NS))
      fci_flash_model_i (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .reset_powerdown_n_i(pdown_n), .unlock_i(unl), .vpp_i(vpp),
      .addr_i(fa), .dq_i(dq_i), .dq_o(fdq), .drive_o(fdrv));

   // ==================================================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask

   // classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] ad,
                     input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= v;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask

   // start an op and poll until the sequencer is idle again
   task automatic run(input logic [3:0] op);
      int n;
      wb(1'b1, REG_CTRL, {28'h0, op});
      n = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (q[ST_BUSY] !== 1'b0 && n < 100);
      // a sequencer that never goes idle must not pass silently
      if (n >= 100) chk(32'h0, 32'h1);
   endtask

   task automatic raw(input logic [7:0] c);
      wb(1'b1, REG_WDATA, {24'h0, c});
      run(OP_RAW_WRITE);
   endtask

   task automatic see(input logic [15:0] e);
      wb(1'b0, REG_RDATA, 32'h0);
      chk(q, {16'h0, e});
   endtask

   // status byte: ready, erase fail, program fail, supply low
   function automatic logic [15:0] sr_f(input logic r, input logic [2:0] f);
      return {8'h00, r, 1'b0, f, 3'b000};
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #500000;
      n_mismatch++;
      summarize();
   end

   // ==================================================================
   // main sequence
   initial begin
      void'($urandom(32'h02CD));
      {rst_i, cyc, stb, we, adr, sel, wdat} = {4'b1000, 8'h0, 4'hF, 32'h0};
      n_mismatch = 0;
      checked = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_PIN, 32'h0);
      chk(q, 32'h1);
      chk(pdown_n, 1'b0);
      wb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, REG_PIN, 32'h4);
      chk({pdown_n, unl, vpp}, 3'b101);
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, REG_ADDR, i);
         run(OP_READ_ID);
         see(i ? DEV : MFR);
      end
      run(OP_READ_ARRAY);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[ST_ID], 1'b0);
      // random programs outside the boot block, one per 4K span
      for (int i = 0; i < 4; i++) begin
         a = 17'h04000 + 17'(i * 4096) + 17'($urandom_range(4095));
         d = 16'($urandom);
         wb(1'b1, REG_ADDR, {15'h0, a});
         wb(1'b1, REG_WDATA, {16'h0, d});
         run(OP_PROGRAM);
         raw(8'h90);
         run(OP_RAW_READ);
         see(sr_f(1'b0, 3'b000));
         repeat (400) @(posedge clk_i);
         run(OP_READ_STATUS);
         see(sr_f(1'b1, 3'b000));
         run(OP_READ_ARRAY);
         run(OP_RAW_READ);
         see(d);
      end
      wb(1'b1, REG_ADDR, 32'h00100);
      run(OP_ERASE);
      run(OP_READ_STATUS);
      see(sr_f(1'b1, 3'b100));
      run(OP_CLEAR);
      run(OP_READ_STATUS);
      see(sr_f(1'b1, 3'b000));
      wb(1'b1, REG_PIN, 32'h0);
      wb(1'b1, REG_ADDR, 32'h0F000);
      run(OP_PROGRAM);
      run(OP_RAW_READ);
      see(sr_f(1'b1, 3'b011));
      wb(1'b1, REG_PIN, 32'h4);
      raw(8'h20);
      raw(8'h90);
      run(OP_RAW_READ);
      see(sr_f(1'b1, 3'b111));
      run(OP_CLEAR);
      raw(8'h20);
      run(OP_READ_ARRAY);
      run(OP_RAW_READ);
      see(16'hFFFF);
      raw(8'h10);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[ST_PEND], 1'b1);
      run(OP_READ_ARRAY);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[ST_PEND], 1'b0);
      repeat (400) @(posedge clk_i);
      wb(1'b1, REG_ADDR, 32'h08000);
      run(OP_ERASE);
      raw(8'hB0);
      run(OP_RAW_READ);
      see(sr_f(1'b1, 3'b000));
      raw(8'hD0);
      run(OP_RAW_READ);
      see(sr_f(1'b0, 3'b000));
      repeat (400) @(posedge clk_i);
      // bad op, reserved code, missing lane: refused and flagged
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, REG_WDATA, 32'h0);
         sel <= (i == 2) ? 4'hE : 4'hF;
         wb(1'b1, REG_CTRL, (i == 0) ? 32'h8 : 32'h0);
         sel <= 4'hF;
         wb(1'b0, REG_STATUS, 32'h0);
         chk(q[1:0], 2'b10);
         wb(1'b1, REG_STATUS, 32'h2);
         wb(1'b0, REG_STATUS, 32'h0);
         chk(q[ST_ERR], 1'b0);
      end
      summarize();
   end
endmodule
